// File: logic/irqre_pkg.sv
// Purpose: Shared constants and carriers for the interrupt request and enable logic.
// Assumes: One 100 MHz clock, synchronous active-high reset, 8-bit register port.
// Notes: Register offsets are the printed byte offsets on the plain register port.
package irqre_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PENDING_GROUP0 = 8'h06;
  localparam logic [7:0] ADDR_PENDING_GROUP1 = 8'h07;
  localparam logic [7:0] ADDR_GATE_GROUP0 = 8'h08;
  localparam logic [7:0] ADDR_GATE_GROUP1 = 8'h09;

  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int MODE_BIT = 7;
  localparam int GROUP0_WIDTH = 7;
  localparam int GROUP1_WIDTH = 6;
  localparam int COMBINED_BIT = 6;
  localparam int INVERT_BIT = 7;
  localparam int PIN_GATE_BIT = 6;
  localparam int PUSH_PULL_BIT = 7;
  localparam int HIGH_LEVEL_BIT = 6;
  localparam int LOW_LEVEL_BIT = 5;
  localparam int COMMAND_END_BIT = 4;
  localparam int TRANSMIT_DONE_BIT = 3;
  localparam int RECEIVE_DONE_BIT = 2;
  localparam int ERROR_BIT = 1;
  localparam int FRAME_START_BIT = 0;
  localparam int CARD_SENSE_BIT = 5;
  localparam int FAULT_COUNT = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] PENDING_GROUP0_RESET = 8'h00;
  localparam logic [7:0] PENDING_GROUP1_RESET = 8'h00;
  localparam logic [7:0] GATE_GROUP0_RESET = 8'h00;
  localparam logic [7:0] GATE_GROUP1_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Register port request, all fields valid in the strobe cycle.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } irqre_bus_t;

  // Event sources; pulses are one cycle wide, warnings and faults are levels.
  typedef struct packed {
    logic fifoHighWarning;
    logic fifoLowWarning;
    logic commandSelfEnd;
    logic unknownCommand;
    logic hostIdleWrite;
    logic transmitLastBit;
    logic receiveEnd;
    logic [4:0] faults;
    logic frameStartSymbol;
    logic subcarrierSeen;
    logic cardSensed;
    logic [4:0] counterUnderflow;
  } irqre_events_t;

endpackage

// File: logic/irqre_event_latch.sv
// Purpose: Sticky request bits with a guarded set or clear write.
// Assumes: Events are already one-cycle set requests.
// Notes: A hardware event in the cycle of a clear write wins over the clear.
`timescale 1ns/1ps
module irqre_event_latch #(
  parameter int W = 7,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic writeHit,
  input wire logic [7:0] writeData,
  input wire logic [W-1:0] events,
  output logic [W-1:0] pending_reg
);

  logic [W-1:0] writeSet;
  logic [W-1:0] writeClear;
  logic [W-1:0] pending_next;

  // Bit 7 of the written value picks set or clear for every ones bit.
  always_comb begin
    writeSet = (writeHit && writeData[irqre_pkg::MODE_BIT]) ? writeData[W-1:0] : '0;
    writeClear = (writeHit && !writeData[irqre_pkg::MODE_BIT]) ? writeData[W-1:0] : '0;
    pending_next = (pending_reg & ~writeClear) | writeSet | events;
  end

  // Pending bits hold until a clear-mode write removes them.
  always_ff @(posedge clock) begin
    if (rst) begin
      pending_reg <= RESET_VALUE;
    end else begin
      pending_reg <= pending_next;
    end
  end

  property p_event_wins;
    @(posedge clock) disable iff (rst)
    (|events) |=> ((pending_reg & $past(events)) == $past(events));
  endproperty
  a_event_wins: assert property (p_event_wins) else $error("event lost");

endmodule

// File: logic/irqre_pin_drive.sv
// Purpose: Interrupt pin stage with polarity and drive style.
// Assumes: Enable output is low while the pin is driven.
// Notes: Open drain only pulls low; a high level releases the pin.
`timescale 1ns/1ps
module irqre_pin_drive (
  input wire logic clock,
  input wire logic rst,
  input wire logic request,
  input wire logic invert,
  input wire logic pushPull,
  output logic pinOut_reg,
  output logic pinOeN_reg
);

  logic pinLevel;

  // Pin level is the request, flipped when inversion is chosen.
  assign pinLevel = request ^ invert; // RULE14

  // Push-pull drives both levels; open drain drives only the low level.
  always_ff @(posedge clock) begin
    if (rst) begin
      pinOut_reg <= 1'b0;
      pinOeN_reg <= 1'b1;
    end else if (pushPull) begin // RULE18
      pinOut_reg <= pinLevel;
      pinOeN_reg <= 1'b0;
    end else begin
      pinOut_reg <= 1'b0;
      pinOeN_reg <= pinLevel;
    end
  end

  property p_open_drain_release;
    @(posedge clock) disable iff (rst)
    (!pushPull && pinLevel) |=> (pinOeN_reg && !pinOut_reg);
  endproperty
  a_open_drain_release: assert property (p_open_drain_release) // RULE18
    else $error("open drain did not release");

endmodule

// File: logic/irqre_top.sv
// Purpose: Interrupt request latching, enable gating and pin drive.
// Assumes: Event inputs synchronous to clock; one strobe per cycle.
// Notes: Read data stand in the cycle after the read strobe only.
//
// Behaviour
// RULE1: Group0 write: ones set or clear per bit7.
// RULE2: Group1 write: ones set or clear per bit7.
// RULE3: High FIFO warning rise latches its bit.
// RULE4: Low FIFO warning rise latches its bit.
// RULE5: Command self end or unknown command sets.
// RULE6: Host idle command write does not set.
// RULE7: Last transmitted bit sets transmit done.
// RULE8: Receive end sets bit regardless of errors.
// RULE9: Any listed fault rising sets error bit.
// RULE10: Frame start or subcarrier sets its bit.
// RULE11: Combined request follows any gated pending bit.
// RULE12: Card sensed sets card sense bit.
// RULE13: Counter underflow sets matching counter bit.
// RULE14: Inversion bit flips the pin polarity.
// RULE15: Group0 gates enable group0 requests.
// RULE16: Group0 pending reads zero after reset.
// RULE17: Pin gate passes combined request to pin.
// RULE18: Drive style bit selects push-pull or open drain.
// RULE19: Group1 gates enable card and counter requests.
// RULE20: Pending reads show bits, bit7 reads zero.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module irqre_top (
  input wire logic clock,
  input wire logic rst,
  input wire irqre_pkg::irqre_bus_t busReq,
  input wire irqre_pkg::irqre_events_t events,
  output logic [7:0] readData_reg,
  output logic combinedRequest_reg,
  output logic pinOut,
  output logic pinOeN
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [6:0] pending0;
  logic [5:0] pending1;
  logic [7:0] gate0_reg;
  logic [7:0] gate1_reg;
  logic highPrev_reg;
  logic lowPrev_reg;
  logic [4:0] faultPrev_reg;
  logic [6:0] event0;
  logic [5:0] event1;
  logic hitPending0;
  logic hitPending1;
  logic combined_next;
  logic [7:0] readData_next;

  // True when any pending bit has its gate set.
  function automatic logic anyGated(input logic [6:0] pend, input logic [6:0] gate);
    return |(pend & gate);
  endfunction

  // ---------------------------------------------------------------
  // Register port decode
  // ---------------------------------------------------------------

  // Write hits for the two guarded pending registers.
  assign hitPending0 = busReq.wr && (busReq.addr == irqre_pkg::ADDR_PENDING_GROUP0); // RULE1
  assign hitPending1 = busReq.wr && (busReq.addr == irqre_pkg::ADDR_PENDING_GROUP1); // RULE2

  // Gate registers are plain read-write registers.
  always_ff @(posedge clock) begin
    if (rst) begin
      gate0_reg <= irqre_pkg::GATE_GROUP0_RESET;
      gate1_reg <= irqre_pkg::GATE_GROUP1_RESET;
    end else if (busReq.wr) begin
      if (busReq.addr == irqre_pkg::ADDR_GATE_GROUP0) begin
        gate0_reg <= busReq.wdata;
      end
      if (busReq.addr == irqre_pkg::ADDR_GATE_GROUP1) begin
        gate1_reg <= busReq.wdata;
      end
    end
  end

  // Read mux; mode bit positions and unmapped addresses read zero.
  always_comb begin
    readData_next = irqre_pkg::READ_IDLE;
    if (busReq.rd) begin
      case (busReq.addr)
        irqre_pkg::ADDR_PENDING_GROUP0: begin
          readData_next = {1'b0, pending0}; // RULE20
        end
        irqre_pkg::ADDR_PENDING_GROUP1: begin
          readData_next = {1'b0, combinedRequest_reg, pending1}; // RULE20
        end
        irqre_pkg::ADDR_GATE_GROUP0: begin
          readData_next = gate0_reg;
        end
        irqre_pkg::ADDR_GATE_GROUP1: begin
          readData_next = gate1_reg;
        end
        default: begin
          readData_next = irqre_pkg::READ_IDLE;
        end
      endcase
    end
  end

  // Read data stand for one cycle, then return to zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      readData_reg <= irqre_pkg::READ_IDLE;
    end else begin
      readData_reg <= readData_next;
    end
  end

  // ---------------------------------------------------------------
  // Event conditioning
  // ---------------------------------------------------------------

  // Previous levels of warnings and faults for rise detection.
  always_ff @(posedge clock) begin
    if (rst) begin
      highPrev_reg <= 1'b0;
      lowPrev_reg <= 1'b0;
      faultPrev_reg <= 5'h00;
    end else begin
      highPrev_reg <= events.fifoHighWarning;
      lowPrev_reg <= events.fifoLowWarning;
      faultPrev_reg <= events.faults;
    end
  end

  // Group0 set requests, one per pending bit.
  always_comb begin
    event0 = '0;
    event0[irqre_pkg::HIGH_LEVEL_BIT] = events.fifoHighWarning && !highPrev_reg; // RULE3
    event0[irqre_pkg::LOW_LEVEL_BIT] = events.fifoLowWarning && !lowPrev_reg; // RULE4
    event0[irqre_pkg::COMMAND_END_BIT] = (events.commandSelfEnd || events.unknownCommand) // RULE5
      && !events.hostIdleWrite; // RULE6
    event0[irqre_pkg::TRANSMIT_DONE_BIT] = events.transmitLastBit; // RULE7
    event0[irqre_pkg::RECEIVE_DONE_BIT] = events.receiveEnd; // RULE8
    event0[irqre_pkg::ERROR_BIT] = |(events.faults & ~faultPrev_reg); // RULE9
    event0[irqre_pkg::FRAME_START_BIT] = events.frameStartSymbol || events.subcarrierSeen; // RULE10
  end

  // Group1 set requests: card sense above the five counters.
  assign event1 = {events.cardSensed, events.counterUnderflow}; // RULE12 RULE13

  // ---------------------------------------------------------------
  // Pending registers
  // ---------------------------------------------------------------

  // Group0 pending bits, cleared to zero by reset.
  irqre_event_latch #(
    .W(irqre_pkg::GROUP0_WIDTH),
    .RESET_VALUE(irqre_pkg::PENDING_GROUP0_RESET[6:0]) // RULE16
  ) u_pending0 (
    .clock(clock),
    .rst(rst),
    .writeHit(hitPending0),
    .writeData(busReq.wdata),
    .events(event0),
    .pending_reg(pending0)
  );

  // Group1 pending bits for card sense and counters.
  irqre_event_latch #(
    .W(irqre_pkg::GROUP1_WIDTH),
    .RESET_VALUE(irqre_pkg::PENDING_GROUP1_RESET[5:0])
  ) u_pending1 (
    .clock(clock),
    .rst(rst),
    .writeHit(hitPending1),
    .writeData(busReq.wdata),
    .events(event1),
    .pending_reg(pending1)
  );

  // ---------------------------------------------------------------
  // Combined request and pin
  // ---------------------------------------------------------------

  // Any gated pending bit raises the combined request.
  assign combined_next = anyGated(pending0, gate0_reg[6:0]) // RULE15
    || anyGated({1'b0, pending1}, {1'b0, gate1_reg[5:0]}); // RULE19

  // Combined request follows the gated pending bits one cycle later.
  always_ff @(posedge clock) begin
    if (rst) begin
      combinedRequest_reg <= 1'b0;
    end else begin
      combinedRequest_reg <= combined_next; // RULE11
    end
  end

  // Pin stage: gated combined request, polarity and drive style.
  irqre_pin_drive u_pin (
    .clock(clock),
    .rst(rst),
    .request(combinedRequest_reg && gate1_reg[irqre_pkg::PIN_GATE_BIT]), // RULE17
    .invert(gate0_reg[irqre_pkg::INVERT_BIT]),
    .pushPull(gate1_reg[irqre_pkg::PUSH_PULL_BIT]),
    .pinOut_reg(pinOut),
    .pinOeN_reg(pinOeN)
  );

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  // Set-mode write to group0 raises every ones bit.
  property p_group0_set;
    @(posedge clock) disable iff (rst)
    (hitPending0 && busReq.wdata[7]) |=>
      ((pending0 & $past(busReq.wdata[6:0])) == $past(busReq.wdata[6:0]));
  endproperty
  a_group0_set: assert property (p_group0_set) // RULE1
    else $error("group0 set write failed");

  // Clear-mode write without events drops the ones bits and keeps the rest.
  property p_group0_clear;
    @(posedge clock) disable iff (rst)
    (hitPending0 && !busReq.wdata[7] && event0 == 7'h00) |=>
      (pending0 == ($past(pending0) & ~$past(busReq.wdata[6:0])));
  endproperty
  a_group0_clear: assert property (p_group0_clear) // RULE1
    else $error("group0 clear write failed");

  // Group1 set and clear under the mode bit.
  property p_group1_write;
    @(posedge clock) disable iff (rst)
    (hitPending1 && event1 == 6'h00) |=>
      (pending1 == ($past(busReq.wdata[7]) ? ($past(pending1) | $past(busReq.wdata[5:0]))
        : ($past(pending1) & ~$past(busReq.wdata[5:0]))));
  endproperty
  a_group1_write: assert property (p_group1_write) // RULE2
    else $error("group1 write failed");

  // A rising high warning latches its bit when no group0 write hits.
  sequence s_high_rise;
    !events.fifoHighWarning ##1 events.fifoHighWarning;
  endsequence
  property p_high_latch;
    @(posedge clock) disable iff (rst)
    s_high_rise ##0 !hitPending0 |=> pending0[irqre_pkg::HIGH_LEVEL_BIT];
  endproperty
  a_high_latch: assert property (p_high_latch) // RULE3
    else $error("high warning not latched");

  // Host idle write alone never sets the command end bit.
  property p_host_idle_quiet;
    @(posedge clock) disable iff (rst)
    (events.hostIdleWrite && !pending0[irqre_pkg::COMMAND_END_BIT] && !hitPending0) |=>
      !pending0[irqre_pkg::COMMAND_END_BIT];
  endproperty
  a_host_idle_quiet: assert property (p_host_idle_quiet) // RULE6
    else $error("host idle set command end");

  // A new fault raises the error bit in the next cycle.
  property p_fault_error;
    @(posedge clock) disable iff (rst)
    (|(events.faults & ~faultPrev_reg)) |=> pending0[irqre_pkg::ERROR_BIT];
  endproperty
  a_fault_error: assert property (p_fault_error) // RULE9
    else $error("fault did not raise error bit");

  // Counter 2 underflow sets the matching group1 bit.
  property p_underflow;
    @(posedge clock) disable iff (rst)
    events.counterUnderflow[2] |=> pending1[2];
  endproperty
  a_underflow: assert property (p_underflow) // RULE13
    else $error("underflow not latched");

  // A gated pending bit that stays put raises the combined request.
  property p_combined;
    @(posedge clock) disable iff (rst)
    (pending0[irqre_pkg::TRANSMIT_DONE_BIT] && gate0_reg[irqre_pkg::TRANSMIT_DONE_BIT])
      |=> combinedRequest_reg;
  endproperty
  a_combined: assert property (p_combined) // RULE11
    else $error("combined request missing");

  // Ungated requests alone leave the combined request low.
  property p_gate_blocks;
    @(posedge clock) disable iff (rst)
    (gate0_reg[6:0] == 7'h00 && gate1_reg[5:0] == 6'h00) |=> !combinedRequest_reg;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) // RULE15
    else $error("ungated request reached combined");

  // Pin with gate and push-pull shows the combined request one cycle on.
  sequence s_pin_setup;
    combinedRequest_reg && gate1_reg[irqre_pkg::PIN_GATE_BIT]
      && gate1_reg[irqre_pkg::PUSH_PULL_BIT];
  endsequence
  property p_pin_drive;
    @(posedge clock) disable iff (rst)
    s_pin_setup |=> (pinOut == !$past(gate0_reg[irqre_pkg::INVERT_BIT])) && !pinOeN;
  endproperty
  a_pin_drive: assert property (p_pin_drive) // RULE17
    else $error("pin did not follow request");

  // Group0 pending is zero right after reset.
  property p_reset_zero;
    @(posedge clock) disable iff (rst)
    $fell(rst) |-> (pending0 == 7'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) // RULE16
    else $error("group0 not zero after reset");

  // Mode bit position reads as zero on group0 pending reads.
  property p_read_mode_zero;
    @(posedge clock) disable iff (rst)
    (busReq.rd && busReq.addr == irqre_pkg::ADDR_PENDING_GROUP0) |=>
      (readData_reg == {1'b0, $past(pending0)});
  endproperty
  a_read_mode_zero: assert property (p_read_mode_zero) // RULE20
    else $error("pending read wrong");

endmodule

// File: bench/irqre_host_model.sv
// Purpose: Host-side view of the interrupt pin, with the board pull-up.
// Assumes: The pin has a pull-up, so a released pin reads high.
// Notes: activeLow mirrors the polarity that software chose for the pin.
`timescale 1ns/1ps
module irqre_host_model (
  input wire logic pinOut,
  input wire logic pinOeN,
  input wire logic activeLow,
  output logic pinLevel,
  output logic irqSeen
);
  // The wire takes the driven value, or the pull-up level when released.
  assign pinLevel = pinOeN ? 1'b1 : pinOut;
  // The host decodes its request from the level with the chosen polarity.
  assign irqSeen = pinLevel ^ activeLow;
endmodule

// File: bench/testbench.sv
// Purpose: Self-checking bench for the interrupt request and enable logic.
// Assumes: Register port strobes last one cycle; read data stand one cycle.
// Notes: Expected values come from bench functions, never from the design.
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  irqre_pkg::irqre_bus_t busReq = '0;
  irqre_pkg::irqre_events_t events = '0;
  logic [7:0] readData_reg;
  logic combinedRequest_reg, pinOut, pinOeN, pinLevel, irqSeen, comb, lvl;
  logic [7:0] g0 = 8'h00;
  logic [7:0] g1 = 8'h00;
  logic [7:0] d;
  logic [6:0] p0, p1;
  int mismatches = 0;
  int tests_run = 0;

  irqre_top dut_u (
    .clock(clock),
    .rst(rst),
    .busReq(busReq),
    .events(events),
    .readData_reg(readData_reg),
    .combinedRequest_reg(combinedRequest_reg),
    .pinOut(pinOut),
    .pinOeN(pinOeN)
  );
  irqre_host_model host_u (
    .pinOut(pinOut),
    .pinOeN(pinOeN),
    .activeLow(g0[7]),
    .pinLevel(pinLevel),
    .irqSeen(irqSeen)
  );

  // Free-running 100 MHz clock.
  always #5 clock = ~clock;

  // ---------------------------------------------------------------
  // Tasks and functions
  // ---------------------------------------------------------------
  // Compares a seen value with the expected one and counts the result.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One write cycle on the register port.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    busReq <= '0;
  endtask

  // One read cycle; the data are taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    busReq <= '0;
    #1;
    check(readData_reg, exp);
  endtask

  // Next pending value after a guarded set or clear write.
  function automatic logic [6:0] upd(input logic [6:0] old, input logic [7:0] v);
    return v[7] ? (old | v[6:0]) : (old & ~v[6:0]);
  endfunction

  // Expected read of the pending register hit by event bit i alone.
  function automatic logic [7:0] evExp(input int i);
    case (i)
      19: return 8'h40;
      18: return 8'h20;
      17, 16: return 8'h10;
      15: return 8'h00;
      14: return 8'h08;
      13: return 8'h04;
      12, 11, 10, 9, 8: return 8'h02;
      7, 6: return 8'h01;
      default: return 8'h01 << i;
    endcase
  endfunction

  // Clears all pending bits, fires one event cycle, then reads twice.
  task automatic ev(input logic [19:0] e, input logic [7:0] exp);
    logic [7:0] a;
    a = (e[5:0] != 6'h00) ? 8'h07 : 8'h06;
    wr(8'h06, 8'h7F);
    wr(8'h07, 8'h3F);
    @(posedge clock);
    events <= irqre_pkg::irqre_events_t'(e);
    @(posedge clock);
    events <= '0;
    rd(a, exp);
    rd(a, exp);
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hung run short and counts it as a mismatch.
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(67));
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(8'h06, 8'h00);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h09, 8'h00);
    wr(8'h0A, 8'hFF);
    rd(8'h0A, 8'h00);
    check({6'h00, pinOut, pinOeN}, 8'h00);
    check({7'h00, irqSeen}, 8'h00);
    $display("test reset done");
    p0 = '0;
    p1 = '0;
    for (int n = 0; n < 24; n++) begin
      d = (n == 0) ? 8'hFF : (n == 1) ? 8'h7F : 8'($urandom);
      wr(8'h06, d);
      p0 = upd(p0, d);
      rd(8'h06, {1'b0, p0});
      wr(8'h07, d);
      p1 = upd(p1, {d[7], 1'b0, d[5:0]});
      rd(8'h07, {1'b0, p1});
    end
    $display("test set clear done");
    for (int i = 0; i < 20; i++) begin
      ev(20'h1 << i, evExp(i));
    end
    ev(20'h28000, 8'h00);
    $display("test events done");
    for (int n = 0; n < 16; n++) begin
      g0 = 8'($urandom);
      g1 = 8'($urandom);
      p0 = 7'($urandom);
      p1 = {1'b0, 6'($urandom)};
      if (n == 0) begin
        g0 = 8'h80;
        g1 = 8'h40;
        p0 = '0;
      end
      if (n == 1) begin
        g0 = 8'h01;
        g1 = 8'hC0;
        p0 = 7'h01;
        p1 = '0;
      end
      wr(8'h08, g0);
      wr(8'h09, g1);
      wr(8'h06, 8'h7F);
      wr(8'h07, 8'h3F);
      wr(8'h06, {1'b1, p0});
      wr(8'h07, {2'b11, p1[5:0]});
      repeat (3) @(posedge clock);
      #1;
      comb = (|(p0 & g0[6:0])) | (|(p1[5:0] & g1[5:0]));
      lvl = (comb & g1[6]) ^ g0[7];
      check({7'h00, combinedRequest_reg}, {7'h00, comb});
      check({6'h00, pinOut, pinOeN}, g1[7] ? {6'h00, lvl, 1'b0} : {7'h00, lvl});
      check({7'h00, irqSeen}, {7'h00, comb & g1[6]});
      rd(8'h08, g0);
      rd(8'h09, g1);
      rd(8'h07, {1'b0, comb, p1[5:0]});
    end
    $display("test gating and pin done");
    wr(8'h06, 8'hFF);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(8'h06, 8'h00);
    check({7'h00, combinedRequest_reg}, 8'h00);
    check({6'h00, pinOut, pinOeN}, 8'h00);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
